//--- hdl/dsos_func_mux.sv
`timescale 1ns/1ps
module dsos_func_mux (
  // Selection
  input  wire dsos_pkg::dsos_sel_t  sel,
  input  wire dsos_pkg::dsos_mode_e mode,
  // Sources
  input  wire dsos_pkg::dsos_src_s  src,
  input  wire logic                 move_done,
  input  wire logic                 speed_ok,
  input  wire dsos_pkg::dsos_word_t soft_word,
  // Result
  output logic                      fn_out
);
  import dsos_pkg::*;

  logic internal_position_mode;
  logic spd_mode;

  assign internal_position_mode = (mode == MODE_INTERNAL_POS);
  assign spd_mode               = (mode == MODE_S) || (mode == MODE_SZ);

  always_comb begin
    fn_out = 1'b0;
    if (dsos_is_soft(sel)) begin
      fn_out = soft_word[sel[3:0]];
    end else begin
      case (sel)
        FN_WARN: fn_out = src.rev_limit_err | src.fwd_limit_err |
                          src.op_stop | src.comm_err |
                          src.undervolt;
        FN_OVERFLOW:  fn_out = src.pos_overflow;
        FN_REV_SOFT:  fn_out = src.rev_soft_limit;
        FN_FWD_SOFT:  fn_out = src.fwd_soft_limit;
        FN_MOVE_DONE: fn_out = internal_position_mode &
                               move_done;
        FN_CAPTURE:   fn_out = internal_position_mode &
                               src.capture_done;
        FN_MOTION:    fn_out = internal_position_mode & move_done &
                               src.target_reached;
        FN_SPEED:     fn_out = spd_mode & speed_ok;
        default:      fn_out = 1'b0;
      endcase
    end
  end

endmodule : dsos_func_mux

//--- hdl/dsos_move_tracker.sv
`timescale 1ns/1ps
module dsos_move_tracker (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Motion status
  input  wire dsos_pkg::dsos_motion_s motion,
  input  wire dsos_pkg::dsos_word_t   speed_win,
  // Derived indications
  output logic                    move_done,
  output logic                    speed_ok
);
  import dsos_pkg::*;

  typedef struct packed {
    logic move_done;
  } dsos_trk_s;

  dsos_trk_s state;
  dsos_trk_s next_state;

  // Only command generation is tracked; arrival is target_reached
  always_comb begin
    next_state = state;
    if (motion.cmd_finish) begin
      next_state.move_done = 1'b1;
    end
    // A new command starting in the same cycle outranks the old finish
    if (motion.cmd_start) begin
      next_state.move_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign move_done = state.move_done;
  assign speed_ok  = dsos_mag(motion.speed_err) <= speed_win;

endmodule : dsos_move_tracker

//--- hdl/dsos_pkg.sv
package dsos_pkg;

  localparam int NUM_OUT = 5;
  localparam int SEL_W   = 8;
  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 4;

  typedef logic [SEL_W-1:0]   dsos_sel_t;
  typedef logic [WORD_W-1:0]  dsos_word_t;
  typedef logic [ADDR_W-1:0]  dsos_addr_t;
  typedef logic [NUM_OUT-1:0] dsos_vec_t;

  // Output function codes
  localparam dsos_sel_t FN_OFF        = 8'h00;
  localparam dsos_sel_t FN_WARN       = 8'h11;
  localparam dsos_sel_t FN_OVERFLOW   = 8'h12;
  localparam dsos_sel_t FN_REV_SOFT   = 8'h13;
  localparam dsos_sel_t FN_FWD_SOFT   = 8'h14;
  localparam dsos_sel_t FN_MOVE_DONE  = 8'h15;
  localparam dsos_sel_t FN_CAPTURE    = 8'h16;
  localparam dsos_sel_t FN_MOTION     = 8'h17;
  localparam dsos_sel_t FN_SPEED      = 8'h19;
  localparam dsos_sel_t FN_SOFT_FIRST = 8'h30;
  localparam dsos_sel_t FN_SOFT_LAST  = 8'h3f;

  // Register map, one register per address, read as a 16-bit word (select codes 8 bits, status, mask and pins 5 bits)
  localparam dsos_addr_t REG_SEL_BASE  = 4'h0;
  localparam dsos_addr_t REG_SOFT_WORD = 4'h5;
  localparam dsos_addr_t REG_SPEED_WIN = 4'h6;
  localparam dsos_addr_t REG_STATUS    = 4'h7;
  localparam dsos_addr_t REG_MASK      = 4'h8;
  localparam dsos_addr_t REG_PINS      = 4'h9;

  // Reset values
  localparam dsos_sel_t  SEL_RST       = 8'h00;
  localparam dsos_word_t SOFT_WORD_RST = 16'h0000;
  localparam dsos_word_t SPEED_WIN_RST = 16'h0000;
  localparam dsos_vec_t  STATUS_RST    = 5'h00;
  localparam dsos_vec_t  MASK_RST      = 5'h00;
  localparam dsos_vec_t  PINS_RST      = 5'h00;

  typedef enum logic [2:0] {
    MODE_PT           = 3'h0,
    MODE_INTERNAL_POS = 3'h1,
    MODE_S            = 3'h2,
    MODE_T            = 3'h3,
    MODE_SZ           = 3'h4,
    MODE_TZ           = 3'h5
  } dsos_mode_e;

  typedef struct packed {
    logic rev_limit_err;
    logic fwd_limit_err;
    logic op_stop;
    logic comm_err;
    logic undervolt;
    logic pos_overflow;
    logic rev_soft_limit;
    logic fwd_soft_limit;
    logic capture_done;
    logic target_reached;
  } dsos_src_s;

  typedef struct packed {
    logic       cmd_start;
    logic       cmd_finish;
    dsos_word_t speed_err;
  } dsos_motion_s;

  // Magnitude of a two's complement speed error
  function automatic dsos_word_t dsos_mag(input dsos_word_t v);
    dsos_mag = v[WORD_W-1] ? dsos_word_t'(~v + 16'h0001) : v;
  endfunction : dsos_mag

  function automatic logic dsos_is_soft(input dsos_sel_t s);
    dsos_is_soft = (s >= FN_SOFT_FIRST) && (s <= FN_SOFT_LAST);
  endfunction : dsos_is_soft

endpackage : dsos_pkg

//--- hdl/dsos_selector.sv
// Functional notes
// - Code 0x11 shows any warning-class alarm
// - Code 0x12 shows position command overflow
// - Code 0x13 shows reverse soft limit
// - Code 0x14 shows forward soft limit
// - Code 0x15 shows move done, internal mode
// - Move done low while command executes
// - Move done ignores actual target arrival
// - Code 0x16 shows capture done, internal mode
// - Code 0x17 is move done AND target, internal mode
// - Code 0x19 shows speed error within window, modes S and SZ
// - Codes 0x30-0x32 show soft word bits
// - Soft word mapping continues to 0x3f
// - Code zero disables the output
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module dsos_selector (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Register port
  input  wire dsos_pkg::dsos_addr_t reg_addr,
  input  wire dsos_pkg::dsos_word_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output dsos_pkg::dsos_word_t      reg_rdata,
  // Drive status sources
  input  wire dsos_pkg::dsos_mode_e   mode,
  input  wire dsos_pkg::dsos_src_s    src,
  input  wire dsos_pkg::dsos_motion_s motion,
  // Status output pins and interrupt
  output dsos_pkg::dsos_vec_t       status_pins,
  output logic                      irq
);
  import dsos_pkg::*;

  typedef struct packed {
    dsos_sel_t [NUM_OUT-1:0] sel;
    dsos_word_t              soft_word;
    dsos_word_t              speed_win;
    dsos_vec_t               status;
    dsos_vec_t               mask;
    dsos_vec_t               pins;
    dsos_word_t              rdata;
  } dsos_regs_s;

  dsos_regs_s state;
  dsos_regs_s next_state;

  logic      move_done;
  logic      speed_ok;
  dsos_vec_t fn_val;
  dsos_vec_t rise;

  dsos_move_tracker u_tracker (
    .core_clk  (core_clk),
    .reset     (reset),
    .motion    (motion),
    .speed_win (state.speed_win),
    .move_done (move_done),
    .speed_ok  (speed_ok)
  );

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    dsos_func_mux u_mux (
      .sel       (state.sel[i]),
      .mode      (mode),
      .src       (src),
      .move_done (move_done),
      .speed_ok  (speed_ok),
      .soft_word (state.soft_word),
      .fn_out    (fn_val[i])
    );
  end

  // A pin going active is the event that software may be woken by
  assign rise = fn_val & ~state.pins;

  function automatic dsos_word_t read_mux(input dsos_regs_s s,
                                          input dsos_addr_t a);
    read_mux = '0;
    if (a < REG_SEL_BASE + dsos_addr_t'(NUM_OUT)) begin
      read_mux = {8'h00, s.sel[a[2:0]]};
    end else begin
      case (a)
        REG_SOFT_WORD: read_mux = s.soft_word;
        REG_SPEED_WIN: read_mux = s.speed_win;
        REG_STATUS:    read_mux = {11'h000, s.status};
        REG_MASK:      read_mux = {11'h000, s.mask};
        REG_PINS:      read_mux = {11'h000, s.pins};
        default:       read_mux = '0;
      endcase
    end
  endfunction : read_mux

  always_comb begin
    next_state = state;
    // Pins follow their source every cycle, never latched
    next_state.pins  = fn_val;
    next_state.rdata = '0;
    if (reg_rd) begin
      next_state.rdata = read_mux(state, reg_addr);
    end
    if (reg_wr) begin
      if (reg_addr < REG_SEL_BASE + dsos_addr_t'(NUM_OUT)) begin
        next_state.sel[reg_addr[2:0]] = reg_wdata[SEL_W-1:0];
      end else begin
        case (reg_addr)
          REG_SOFT_WORD: next_state.soft_word = reg_wdata;
          REG_SPEED_WIN: next_state.speed_win = reg_wdata;
          REG_MASK:      next_state.mask      = reg_wdata[NUM_OUT-1:0];
          default:       next_state.mask      = state.mask;
        endcase
      end
    end
    // Read clears, but an edge in the same cycle survives the clear
    if (reg_rd && reg_addr == REG_STATUS) begin
      next_state.status = '0;
    end
    next_state.status = next_state.status | rise;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state.sel       <= {NUM_OUT{SEL_RST}};
      state.soft_word <= SOFT_WORD_RST;
      state.speed_win <= SPEED_WIN_RST;
      state.status    <= STATUS_RST;
      state.mask      <= MASK_RST;
      state.pins      <= PINS_RST;
      state.rdata     <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status_pins = state.pins;
  assign reg_rdata   = state.rdata;
  assign irq         = |(state.status & state.mask);

  // Checks on output 0 except a_soft_top on output 4; the other channels share the same mux
  logic warn_any;
  assign warn_any = src.rev_limit_err | src.fwd_limit_err | src.op_stop |
                    src.comm_err | src.undervolt;

  property p_warn;
    @(posedge core_clk) disable iff (reset)
      (state.sel[0] == FN_WARN) && warn_any |=> status_pins[0];
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning code did not raise output");

  property p_overflow;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_OVERFLOW |=>
        status_pins[0] == $past(src.pos_overflow);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow output does not follow source");

  property p_rev_soft;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_REV_SOFT |=>
        status_pins[0] == $past(src.rev_soft_limit);
  endproperty
  a_rev_soft: assert property (p_rev_soft)
    else $error("reverse soft limit output wrong");

  property p_fwd_soft;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_FWD_SOFT |=>
        status_pins[0] == $past(src.fwd_soft_limit);
  endproperty
  a_fwd_soft: assert property (p_fwd_soft)
    else $error("forward soft limit output wrong");

  logic move_sel;
  assign move_sel = (state.sel[0] == FN_MOVE_DONE) &&
                    (mode == MODE_INTERNAL_POS);

  property p_move_start;
    @(posedge core_clk) disable iff (reset)
      move_sel && motion.cmd_start ##1 move_sel
        |=> !status_pins[0];
  endproperty
  a_move_start: assert property (p_move_start)
    else $error("move done output high while executing");

  property p_move_finish;
    @(posedge core_clk) disable iff (reset)
      move_sel && motion.cmd_finish && !motion.cmd_start
        ##1 move_sel |=> status_pins[0];
  endproperty
  a_move_finish: assert property (p_move_finish)
    else $error("move done output missing after finish");

  property p_capture;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_CAPTURE |=>
        status_pins[0] == ($past(mode) == MODE_INTERNAL_POS &&
                           $past(src.capture_done));
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture done output wrong");

  property p_motion;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_MOTION && mode == MODE_INTERNAL_POS &&
      !src.target_reached |=> !status_pins[0];
  endproperty
  a_motion: assert property (p_motion)
    else $error("motion done without target reached");

  property p_speed;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_SPEED |=>
        status_pins[0] == (($past(mode) == MODE_S ||
                            $past(mode) == MODE_SZ) &&
                           dsos_mag($past(motion.speed_err)) <=
                           $past(state.speed_win));
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed reached output wrong");

  property p_soft;
    @(posedge core_clk) disable iff (reset)
      dsos_is_soft(state.sel[0]) |=>
        status_pins[0] ==
          $past(state.soft_word[state.sel[0][3:0]]);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft word bit output wrong");

  property p_off;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_OFF |=> !status_pins[0];
  endproperty
  a_off: assert property (p_off)
    else $error("disabled output is active");

  property p_mode_gate;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_MOVE_DONE && mode != MODE_INTERNAL_POS
        |=> !status_pins[0];
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("mode-restricted output active in wrong mode");

  property p_unassigned;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == 8'h18 || state.sel[0] == 8'h40 ||
      state.sel[0] == 8'hff |=> !status_pins[0];
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned code drove output");

  property p_irq;
    @(posedge core_clk) disable iff (reset)
      rise[0] && state.mask[0] && !(reg_wr && reg_addr == REG_MASK)
        |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing after pin edge");

  property p_read_data;
    @(posedge core_clk) disable iff (reset)
      reg_rd && reg_addr == REG_SOFT_WORD |=>
        reg_rdata == $past(state.soft_word);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data wrong one cycle after strobe");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_sel_write;
    @(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == REG_SEL_BASE |=>
        state.sel[0] == $past(reg_wdata[SEL_W-1:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select code write did not land");

  // Status is sticky: only a read of it may drop a bit
  property p_status_hold;
    @(posedge core_clk) disable iff (reset)
      state.status[0] && !(reg_rd && reg_addr == REG_STATUS) |=>
        state.status[0];
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status bit lost without a read");

  property p_status_clear;
    @(posedge core_clk) disable iff (reset)
      reg_rd && reg_addr == REG_STATUS && !rise[0] |=>
        !state.status[0];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit not cleared by read");

  property p_warn_low;
    @(posedge core_clk) disable iff (reset)
      state.sel[0] == FN_WARN && !warn_any |=> !status_pins[0];
  endproperty
  a_warn_low: assert property (p_warn_low)
    else $error("warning output high without a condition");

  // Output 4 is where the highest soft code is exercised
  property p_soft_top;
    @(posedge core_clk) disable iff (reset)
      dsos_is_soft(state.sel[4]) |=>
        status_pins[4] == $past(state.soft_word[state.sel[4][3:0]]);
  endproperty
  a_soft_top: assert property (p_soft_top)
    else $error("soft word bit wrong on output 4");

  property p_start_clears;
    @(posedge core_clk) disable iff (reset)
      motion.cmd_start |=> !move_done;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("move done still set after command start");

  // Arrival at the target must never set move done on its own
  property p_done_source;
    @(posedge core_clk) disable iff (reset)
      $rose(move_done) |-> $past(motion.cmd_finish) &&
                           !$past(motion.cmd_start);
  endproperty
  a_done_source: assert property (p_done_source)
    else $error("move done rose without a command finish");

  c_move: cover property (@(posedge core_clk) disable iff (reset)
    move_sel ##1 status_pins[0]);
  c_motion: cover property (@(posedge core_clk) disable iff (reset)
    state.sel[0] == FN_MOTION ##1 status_pins[0]);
  c_speed: cover property (@(posedge core_clk) disable iff (reset)
    state.sel[0] == FN_SPEED ##1 status_pins[0]);
  c_soft: cover property (@(posedge core_clk) disable iff (reset)
    state.sel[0] == FN_SOFT_LAST ##1 status_pins[0]);
  c_irq: cover property (@(posedge core_clk) disable iff (reset)
    irq ##1 reg_rd && reg_addr == REG_STATUS ##1 !irq);

endmodule : dsos_selector

//--- test/dsos_ctrl_model.sv
`timescale 1ns/1ps
module dsos_ctrl_model (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // Pins from the drive
  input  wire dsos_pkg::dsos_vec_t status_pins,
  // Sampled view of the controller
  output dsos_pkg::dsos_vec_t      pins_seen
);
  import dsos_pkg::*;

  // Registered input stage: the controller never sees the pins before
  // they have been stable across one of its own clock edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pins_seen <= PINS_RST;
    end else begin
      pins_seen <= status_pins;
    end
  end

endmodule : dsos_ctrl_model

//--- test/dsos_selector_tb_top.sv
`timescale 1ns/1ps
module dsos_selector_tb_top;
  import dsos_pkg::*;

  logic         core_clk;
  logic         reset;
  dsos_addr_t   reg_addr;
  dsos_word_t   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  dsos_word_t   reg_rdata;
  dsos_mode_e   mode;
  dsos_src_s    src;
  dsos_motion_s motion;
  dsos_vec_t    status_pins;
  logic         irq;
  dsos_vec_t    pins_seen;
  dsos_word_t   spd;
  dsos_word_t   word;
  dsos_sel_t    bad [6];
  int           num_errors;
  int           n_checks;
  int           i;

  dsos_selector DUT (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode(mode), .src(src), .motion(motion),
    .status_pins(status_pins), .irq(irq)
  );

  dsos_ctrl_model host (
    .core_clk(core_clk), .reset(reset), .status_pins(status_pins),
    .pins_seen(pins_seen)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic cmp1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  task automatic cmp16(input string what, input dsos_word_t exp,
                       input dsos_word_t got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic wr(input dsos_addr_t a, input dsos_word_t d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input dsos_addr_t a, input dsos_word_t exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    cmp16("reg_rdata", exp, reg_rdata);
  endtask : rd

  task automatic drive(input dsos_mode_e m, input dsos_src_s s,
                       input dsos_motion_s mo);
    @(posedge core_clk);
    mode   <= m;
    src    <= s;
    motion <= mo;
  endtask : drive

  // The controller view lags the pins by one more cycle
  task automatic cpin(input int k, input logic exp);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp1("status_pins", exp, pins_seen[k]);
  endtask : cpin

  task automatic cfn(input dsos_sel_t c, input dsos_mode_e m,
                     input dsos_src_s s, input logic exp);
    wr(REG_SEL_BASE, {8'h00, c});
    drive(m, s, '{1'b0, 1'b0, spd});
    cpin(0, exp);
  endtask : cfn

  task automatic pulse(input logic st, input dsos_src_s s);
    drive(MODE_INTERNAL_POS, s, '{st, ~st, 16'h0000});
    drive(MODE_INTERNAL_POS, s, '0);
  endtask : pulse

  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Whole sequence needs well under 2000 cycles; ten times that is a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    reset      = 1'b1;
    reg_addr   = '0;
    reg_wdata  = '0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    mode       = MODE_PT;
    src        = '0;
    motion     = '0;
    spd        = '0;
    word       = 16'ha5c3;
    bad        = '{8'h00, 8'h18, 8'h1a, 8'h2f, 8'h40, 8'hff};
    num_errors = 0;
    n_checks   = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    cmp1("irq", 1'b0, irq);
    for (i = 0; i < 11; i++) begin
      rd(dsos_addr_t'(i), 16'h0000);
    end
    // Sticky status, interrupt and read-only places
    wr(REG_MASK, 16'h0001);
    cfn(FN_OVERFLOW, MODE_PT, 10'h010, 1'b1);
    cmp1("irq", 1'b1, irq);
    rd(REG_PINS, 16'h0001);
    rd(REG_STATUS, 16'h0001);
    @(negedge core_clk);
    cmp1("irq", 1'b0, irq);
    rd(REG_STATUS, 16'h0000);
    wr(REG_PINS, 16'h001f);
    wr(REG_STATUS, 16'h001f);
    wr(4'hc, 16'hffff);
    rd(REG_PINS, 16'h0001);
    rd(REG_STATUS, 16'h0000);
    rd(4'hc, 16'h0000);
    wr(REG_MASK, 16'h0000);
    cfn(FN_OVERFLOW, MODE_PT, 10'h000, 1'b0);
    cfn(FN_OVERFLOW, MODE_PT, 10'h010, 1'b1);
    cmp1("irq", 1'b0, irq);
    rd(REG_STATUS, 16'h0001);
    // One source per code, every other source ignored
    for (i = 5; i < 10; i++) begin
      cfn(FN_WARN, MODE_TZ, dsos_src_s'(10'h001 << i), 1'b1);
    end
    cfn(FN_WARN, MODE_TZ, 10'h01f, 1'b0);
    cfn(FN_OVERFLOW, MODE_S, 10'h3ef, 1'b0);
    cfn(FN_REV_SOFT, MODE_SZ, 10'h008, 1'b1);
    cfn(FN_REV_SOFT, MODE_SZ, 10'h3f7, 1'b0);
    cfn(FN_FWD_SOFT, MODE_INTERNAL_POS, 10'h004, 1'b1);
    cfn(FN_FWD_SOFT, MODE_INTERNAL_POS, 10'h3fb, 1'b0);
    cfn(FN_CAPTURE, MODE_INTERNAL_POS, 10'h002, 1'b1);
    cfn(FN_CAPTURE, MODE_PT, 10'h002, 1'b0);
    cfn(FN_CAPTURE, dsos_mode_e'(3'h6), 10'h002, 1'b0);
    // Speed window boundary, both signs
    wr(REG_SPEED_WIN, 16'h0010);
    rd(REG_SPEED_WIN, 16'h0010);
    spd = 16'h0010;
    cfn(FN_SPEED, MODE_S, '0, 1'b1);
    spd = 16'h0011;
    cfn(FN_SPEED, MODE_S, '0, 1'b0);
    spd = 16'hfff0;
    cfn(FN_SPEED, MODE_SZ, '0, 1'b1);
    spd = 16'h0000;
    cfn(FN_SPEED, MODE_T, '0, 1'b0);
    // Software word, every bit
    wr(REG_SOFT_WORD, word);
    for (i = 0; i < 16; i++) begin
      cfn(FN_SOFT_FIRST + dsos_sel_t'(i), MODE_T, '0, word[i]);
    end
    wr(REG_SEL_BASE + 4'h4, 16'h003f);
    cpin(4, word[15]);
    rd(REG_SEL_BASE + 4'h4, 16'h003f);
    wr(REG_SEL_BASE + 4'h2, 16'h0031);
    cpin(2, word[1]);
    wr(REG_SEL_BASE + 4'h3, 16'h0032);
    cpin(3, word[2]);
    cpin(1, 1'b0);
    cfn(FN_SOFT_FIRST, MODE_T, '0, 1'b1);
    wr(REG_SOFT_WORD, 16'h0000);
    cpin(0, 1'b0);
    // Off code and unassigned codes with every source active
    wr(REG_SOFT_WORD, 16'hffff);
    for (i = 0; i < 6; i++) begin
      cfn(bad[i], MODE_INTERNAL_POS, 10'h3ff, 1'b0);
    end
    // Internal move done and motion done
    cfn(FN_MOVE_DONE, MODE_INTERNAL_POS, '0, 1'b0);
    pulse(1'b1, '0);
    cpin(0, 1'b0);
    pulse(1'b0, '0);
    cpin(0, 1'b1);
    cfn(FN_MOVE_DONE, MODE_S, '0, 1'b0);
    cfn(FN_MOTION, MODE_INTERNAL_POS, 10'h000, 1'b0);
    cfn(FN_MOTION, MODE_INTERNAL_POS, 10'h001, 1'b1);
    cfn(FN_MOTION, MODE_S, 10'h001, 1'b0);
    cfn(FN_MOTION, MODE_INTERNAL_POS, 10'h001, 1'b1);
    pulse(1'b1, 10'h001);
    cpin(0, 1'b0);
    cfn(FN_MOVE_DONE, MODE_INTERNAL_POS, 10'h001, 1'b0);
    print_verdict();
  end

endmodule : dsos_selector_tb_top
